// ---- rtc_consts.svh ----
// Constant offsets, field positions, reset values and counts of the clock block
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH

// ==========================================
// Command byte
`define RTC_CMD_BURST_WR 8'h3F
`define RTC_CMD_BURST_RD 8'hBF
`define RTC_CMD_RD_BIT 7
`define RTC_CMD_RAM_BIT 6
`define RTC_CMD_EN_BIT 0
`define RTC_BURST_BYTES 4'h8
`define RTC_IDX_CTRL 5'h07
`define RTC_IDX_CENT 5'h09

// ==========================================
// Field positions
`define RTC_HR_12_BIT 7
`define RTC_HR_PM_BIT 5
`define RTC_WP_BIT 7

// ==========================================
// Field limits, packed decimal
`define RTC_SEC_TOP 8'h59
`define RTC_MIN_TOP 8'h59
`define RTC_HR24_TOP 6'h23
`define RTC_HR12_TOP 5'h12
`define RTC_HR12_PRE 5'h11
`define RTC_HR12_LOW 5'h01
`define RTC_DAY_TOP 8'h07
`define RTC_MON_TOP 8'h12
`define RTC_YEAR_TOP 8'h99
`define RTC_CENT_TOP 8'h99

// ==========================================
// Reset values
`define RTC_RST_SEC 8'h00
`define RTC_RST_MIN 8'h00
`define RTC_RST_HOUR 8'h00
`define RTC_RST_DATE 8'h01
`define RTC_RST_MON 8'h01
`define RTC_RST_DAY 8'h01
`define RTC_RST_YEAR 8'h70
`define RTC_RST_CENT 8'h19

// ==========================================
// Crystal prescaler
`define RTC_XTAL_DIV 32768
`define RTC_PRE_W 15

`endif

// ---- rtc_pkg.sv ----
// Types shared by the clock core and its serial port
`include "rtc_consts.svh"
package rtc_pkg;
  typedef logic [7:0] rtc_byte_t;

  // ==========================================
  // Clock core state
  typedef struct packed {
    logic [2:0] xs;
    logic [2:0] cs;
    logic [`RTC_PRE_W-1:0] pre;
    rtc_byte_t [6:0] tk;
    logic wp;
    rtc_byte_t cent;
    logic pend;
    rtc_byte_t [8:0] snap;
  } rtc_core_s;

  // ==========================================
  // Serial port state
  typedef struct packed {
    logic [2:0] bits;
    logic [3:0] nbytes;
    rtc_byte_t sh;
    rtc_byte_t cmd;
    logic have_cmd;
  } rtc_rx_s;

  typedef struct packed {
    rtc_byte_t [7:0] wbuf;
    logic [4:0] addr;
    logic burst;
    logic valid;
  } rtc_hold_s;

  typedef struct packed {
    logic [2:0] bits;
    logic [3:0] idx;
    rtc_byte_t sh;
    logic dout;
  } rtc_tx_s;
endpackage

// ---- rtc_link_if.sv ----
// Carrier between the clock core and the serial port
`timescale 1ns/10ps
interface rtc_link_if;
  import rtc_pkg::*;
  rtc_byte_t [8:0] snap;
  rtc_byte_t [7:0] wbuf;
  logic [4:0] waddr;
  logic wburst;
  logic wvalid;
  modport core (output snap, input wbuf, input waddr, input wburst, input wvalid);
  modport port (input snap, output wbuf, output waddr, output wburst, output wvalid);
endinterface

// ---- rtc_spi_port.sv ----
// Serial port on the link clock: command decode, input buffer, read shifter
`timescale 1ns/10ps
module rtc_spi_port
  import rtc_pkg::*;
(
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout,
  output logic dout_oe,
  rtc_link_if.port link
);
  rtc_rx_s rx_r, rx_nxt;
  rtc_hold_s hd_r, hd_nxt;
  rtc_tx_s tx_r, tx_nxt;
  rtc_byte_t rx_byte;
  rtc_byte_t tx_byte;
  logic byte_done;
  logic wr_ok;
  logic rd_on;

  // ==========================================
  // Read byte selection
  function automatic rtc_byte_t read_sel(input rtc_byte_t cmd, input logic [3:0] idx,
                                         input rtc_byte_t [8:0] s);
    logic [4:0] a;
    a = cmd[5:1];
    if (cmd == `RTC_CMD_BURST_RD) begin
      return (idx < `RTC_BURST_BYTES) ? s[idx[2:0]] : 8'h00;
    end
    if (cmd[`RTC_CMD_RAM_BIT] || idx != 4'h0) begin
      return 8'h00;
    end
    if (a <= `RTC_IDX_CTRL) begin
      return s[a[2:0]];
    end
    if (a == `RTC_IDX_CENT) begin
      return s[8];
    end
    return 8'h00;
  endfunction

  // ==========================================
  // Input side, rising edges
  always_comb begin
    rx_nxt = rx_r;
    hd_nxt = hd_r;
    rx_byte = {rx_r.sh[6:0], din};
    rx_nxt.sh = rx_byte;
    rx_nxt.bits = rx_r.bits + 3'h1;
    byte_done = (rx_r.bits == 3'h7);
    wr_ok = rx_r.have_cmd & ~rx_r.cmd[`RTC_CMD_RD_BIT] & ~rx_r.cmd[`RTC_CMD_RAM_BIT]
            & rx_r.cmd[`RTC_CMD_EN_BIT];
    if (!rx_r.have_cmd && rx_r.bits == 3'h0) begin
      hd_nxt.valid = 1'b0;
    end
    if (byte_done) begin
      if (!rx_r.have_cmd) begin
        rx_nxt.cmd = rx_byte;
        rx_nxt.have_cmd = 1'b1;
      end else if (rx_r.nbytes != 4'hF) begin
        rx_nxt.nbytes = rx_r.nbytes + 4'h1;
      end
    end
    if (byte_done && wr_ok) begin
      if (rx_r.cmd == `RTC_CMD_BURST_WR) begin
        if (rx_r.nbytes < `RTC_BURST_BYTES) begin
          hd_nxt.wbuf[rx_r.nbytes[2:0]] = rx_byte;
          hd_nxt.burst = 1'b1;
          hd_nxt.addr = rx_r.cmd[5:1];
        end
        if (rx_r.nbytes == `RTC_BURST_BYTES - 4'h1) begin
          hd_nxt.valid = 1'b1;
        end
      end else if (rx_r.nbytes == 4'h0) begin
        hd_nxt.wbuf[0] = rx_byte;
        hd_nxt.addr = rx_r.cmd[5:1];
        hd_nxt.burst = 1'b0;
        hd_nxt.valid = 1'b1;
      end
    end
  end

  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      rx_r <= '0;
    end else begin
      rx_r <= rx_nxt;
    end
  end

  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      hd_r <= '0;
    end else begin
      hd_r <= hd_nxt;
    end
  end

  // ==========================================
  // Output side, falling edges
  always_comb begin
    tx_nxt = tx_r;
    tx_byte = read_sel(rx_r.cmd, tx_r.idx, link.snap);
    rd_on = rx_r.have_cmd & rx_r.cmd[`RTC_CMD_RD_BIT];
    if (rd_on) begin
      if (tx_r.bits == 3'h0) begin
        tx_nxt.dout = tx_byte[7];
        tx_nxt.sh = {tx_byte[6:0], 1'b0};
      end else begin
        tx_nxt.dout = tx_r.sh[7];
        tx_nxt.sh = {tx_r.sh[6:0], 1'b0};
      end
      tx_nxt.bits = tx_r.bits + 3'h1;
      if (tx_r.bits == 3'h7 && tx_r.idx != 4'hF) begin
        tx_nxt.idx = tx_r.idx + 4'h1;
      end
    end
  end

  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      tx_r <= '0;
    end else begin
      tx_r <= tx_nxt;
    end
  end

  assign dout = tx_r.dout;
  assign dout_oe = ~cs_n & rx_r.have_cmd & rx_r.cmd[`RTC_CMD_RD_BIT];
  assign link.wbuf = hd_r.wbuf;
  assign link.waddr = hd_r.addr;
  assign link.wburst = hd_r.burst;
  assign link.wvalid = hd_r.valid;
endmodule

// ---- rtc_core.sv ----
// Timekeeping counters, buffered time update and read snapshot of the clock
//
// Notes on behaviour
// - Write bytes go to an input buffer; counters keep counting meanwhile.
// - Committing buffered time never happens in a seconds-increment cycle.
// - Buffered time moves into the counters only after chip select rises.
// - An unfinished write is cancelled; buffer dropped, counters untouched.
// - Written time is readable by the next read after select rises.
// - Clock burst write needs at least eight full data bytes, else no update.
// - A complete burst write loads all seven time fields at once.
// - Hours bit 7 high selects 12-hour mode, low selects 24-hour mode.
// - Hours bit 5 is PM in 12-hour mode, twenty-hours digit in 24-hour.
// - Control bit 7 set blocks all writes except to that bit and burst writes that clear it.
// - Control bits 0 to 6 read zero and ignore written values.
// - Command 3Fh is clock burst write; century written alone, resets 19.
// - Reads use a snapshot that never catches a seconds increment midway.
// - Counters keep running while a read is in progress.
// - Burst read sends seconds through year, then control, eight bytes.
// - Burst read latches all fields, century included, together.
// - Command bit 7 low writes, high reads; BFh is clock burst read.
// - Command bit 0 must be one; zero disables writes.
// - Input sampled on rising serial clock, output shifted on falling, MSB first.
`timescale 1ns/10ps
module rtc_core
  import rtc_pkg::*;
#(
  parameter int XTAL_DIV = `RTC_XTAL_DIV
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic xtal_32k,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout,
  output logic dout_oe
);
  localparam logic [`RTC_PRE_W-1:0] PRE_TOP = `RTC_PRE_W'(XTAL_DIV - 1);

  rtc_link_if link ();
  rtc_core_s r_r, r_nxt;
  logic xtal_edge;
  logic tick;
  logic commit_edge;
  logic cy;
  logic [8:0] st;

  // ==========================================
  // Packed decimal helpers
  // decimal digit carry
  function automatic logic [8:0] bcd_step(input rtc_byte_t v, input rtc_byte_t top,
                                          input rtc_byte_t low);
    if (v == top) begin
      return {1'b1, low};
    end
    if (v[3:0] == 4'h9) begin
      return {1'b0, v[7:4] + 4'h1, 4'h0};
    end
    return {1'b0, v[7:4], v[3:0] + 4'h1};
  endfunction

  function automatic logic [8:0] hour_step(input rtc_byte_t h);
    if (h[`RTC_HR_12_BIT]) begin
      // PM flag toggles at eleven to twelve
      if (h[4:0] == `RTC_HR12_TOP) begin
        return {1'b0, h[7:5], `RTC_HR12_LOW};
      end
      if (h[4:0] == `RTC_HR12_PRE) begin
        return {h[`RTC_HR_PM_BIT], h[7:6], ~h[`RTC_HR_PM_BIT], `RTC_HR12_TOP};
      end
      if (h[3:0] == 4'h9) begin
        return {1'b0, h[7:5], 5'h10};
      end
      return {1'b0, h[7:4], h[3:0] + 4'h1};
    end
    if (h[5:0] == `RTC_HR24_TOP) begin
      return {1'b1, h[7:6], 6'h00};
    end
    if (h[3:0] == 4'h9) begin
      return {1'b0, h[7:6], h[5:4] + 2'h1, 4'h0};
    end
    return {1'b0, h[7:4], h[3:0] + 4'h1};
  endfunction

  function automatic rtc_byte_t month_len(input rtc_byte_t m, input rtc_byte_t y);
    logic [1:0] q;
    q = {y[4], 1'b0} + y[1:0];
    case (m)
      8'h02: month_len = (q == 2'h0) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
      default: month_len = 8'h31;
    endcase
  endfunction

  // ==========================================
  // Serial port on the link clock
  rtc_spi_port u_port (
    .rst_n(rst_n),
    .sclk(sclk),
    .cs_n(cs_n),
    .din(din),
    .dout(dout),
    .dout_oe(dout_oe),
    .link(link.port)
  );

  // ==========================================
  // Next state
  always_comb begin
    r_nxt = r_r;
    st = '0;
    cy = 1'b0;
    r_nxt.xs = {r_r.xs[1:0], xtal_32k};
    r_nxt.cs = {r_r.cs[1:0], cs_n};
    xtal_edge = r_r.xs[1] & ~r_r.xs[2];
    tick = xtal_edge && (r_r.pre == PRE_TOP);
    commit_edge = r_r.cs[1] & ~r_r.cs[2];
    if (xtal_edge) begin
      r_nxt.pre = tick ? '0 : r_r.pre + 1'b1;
    end
    if (tick) begin
      st = bcd_step(r_r.tk[0], `RTC_SEC_TOP, 8'h00);
      r_nxt.tk[0] = st[7:0];
      cy = st[8];
      if (cy) begin
        st = bcd_step(r_r.tk[1], `RTC_MIN_TOP, 8'h00);
        r_nxt.tk[1] = st[7:0];
        cy = st[8];
      end
      if (cy) begin
        st = hour_step(r_r.tk[2]);
        r_nxt.tk[2] = st[7:0];
        cy = st[8];
      end
      if (cy) begin
        st = bcd_step(r_r.tk[5], `RTC_DAY_TOP, `RTC_RST_DAY);
        r_nxt.tk[5] = st[7:0];
        st = bcd_step(r_r.tk[3], month_len(r_r.tk[4], r_r.tk[6]), `RTC_RST_DATE);
        r_nxt.tk[3] = st[7:0];
        cy = st[8];
      end
      if (cy) begin
        st = bcd_step(r_r.tk[4], `RTC_MON_TOP, `RTC_RST_MON);
        r_nxt.tk[4] = st[7:0];
        cy = st[8];
      end
      if (cy) begin
        st = bcd_step(r_r.tk[6], `RTC_YEAR_TOP, 8'h00);
        r_nxt.tk[6] = st[7:0];
        cy = st[8];
      end
      if (cy) begin
        st = bcd_step(r_r.cent, `RTC_CENT_TOP, 8'h00);
        r_nxt.cent = st[7:0];
      end
    // commit waits out a tick cycle
    end else if (r_r.pend) begin
      // next tick counts on from it
      r_nxt.pend = 1'b0;
      if (link.wburst) begin
        if (!r_r.wp || !link.wbuf[7][`RTC_WP_BIT]) begin
          for (int i = 0; i < 7; i++) begin
            r_nxt.tk[i] = link.wbuf[i];
          end
        end
        r_nxt.wp = link.wbuf[7][`RTC_WP_BIT];
      end else if (link.waddr == `RTC_IDX_CTRL) begin
        r_nxt.wp = link.wbuf[0][`RTC_WP_BIT];
      end else if (!r_r.wp) begin
        if (link.waddr == `RTC_IDX_CENT) begin
          r_nxt.cent = link.wbuf[0];
        end else if (link.waddr < `RTC_IDX_CTRL) begin
          r_nxt.tk[link.waddr[2:0]] = link.wbuf[0];
        end
      end
    end
    // buffer stable for the quiet time
    // New select rise wins over a clear
    if (commit_edge && link.wvalid) begin
      r_nxt.pend = 1'b1;
    end
    if (r_r.cs[1]) begin
      for (int i = 0; i < 7; i++) begin
        r_nxt.snap[i] = r_r.tk[i];
      end
      r_nxt.snap[7] = {r_r.wp, 7'h00};
      r_nxt.snap[8] = r_r.cent;
    end
  end

  // ==========================================
  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_r <= '0;
      r_r.cs <= 3'h7;
      r_r.tk[0] <= `RTC_RST_SEC;
      r_r.tk[1] <= `RTC_RST_MIN;
      r_r.tk[2] <= `RTC_RST_HOUR;
      r_r.tk[3] <= `RTC_RST_DATE;
      r_r.tk[4] <= `RTC_RST_MON;
      r_r.tk[5] <= `RTC_RST_DAY;
      r_r.tk[6] <= `RTC_RST_YEAR;
      r_r.cent <= `RTC_RST_CENT;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign link.snap = r_r.snap;
endmodule

// ---- rtc_core_chk.sv ----
// Port assertions for the clock block
`timescale 1ns/10ps
`include "rtc_consts.svh"
module rtc_core_chk
  import rtc_pkg::*;
#(
  parameter int XTAL_DIV = `RTC_XTAL_DIV
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic xtal_32k,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic dout,
  input wire logic dout_oe
);
  logic [6:0] cnt_r;
  rtc_byte_t cmd_r;
  logic held_r;
  // ========
  // Frame tracking
  always_ff @(posedge sclk or posedge cs_n or negedge rst_n) begin
    if (!rst_n || cs_n) begin
      cnt_r <= 7'h00;
      cmd_r <= 8'h00;
      held_r <= 1'b0;
    end else begin
      cnt_r <= (cnt_r == 7'h7F) ? cnt_r : cnt_r + 7'h01;
      cmd_r <= (cnt_r < 7'h08) ? {cmd_r[6:0], din} : cmd_r;
      held_r <= dout;
    end
  end
  // ========
  // Properties
  property p_oe_idle;
    @(posedge clk) disable iff (!rst_n) cs_n |-> !dout_oe;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("oe while deselected");
  property p_oe_early;
    @(posedge sclk) disable iff (!rst_n || cs_n) cnt_r < 7'h08 |-> !dout_oe;
  endproperty
  a_oe_early: assert property (p_oe_early) else $error("oe during command");
  property p_oe_rd;
    @(posedge sclk) disable iff (!rst_n || cs_n) cnt_r >= 7'h08 && cmd_r[7] |-> dout_oe;
  endproperty
  a_oe_rd: assert property (p_oe_rd) else $error("oe missing on read");
  property p_oe_wr;
    @(posedge sclk) disable iff (!rst_n || cs_n) cnt_r >= 7'h08 && !cmd_r[7] |-> !dout_oe;
  endproperty
  a_oe_wr: assert property (p_oe_wr) else $error("oe on write");
  property p_oe_start;
    @(posedge sclk) disable iff (!rst_n || cs_n) $rose(dout_oe) |-> cnt_r == 7'h08 && cmd_r[7];
  endproperty
  a_oe_start: assert property (p_oe_start) else $error("oe rose late or early");
  property p_dout_hold;
    @(negedge sclk) disable iff (!rst_n || cs_n) dout_oe && cnt_r > 7'h08 |-> dout == held_r;
  endproperty
  a_dout_hold: assert property (p_dout_hold) else $error("dout moved on rise");
  property p_ctl_burst;
    @(posedge sclk) disable iff (!rst_n || cs_n)
      cmd_r == `RTC_CMD_BURST_RD && cnt_r >= 7'd65 && cnt_r <= 7'd71 |-> !dout;
  endproperty
  a_ctl_burst: assert property (p_ctl_burst) else $error("control low bits set");
  property p_ctl_single;
    @(posedge sclk) disable iff (!rst_n || cs_n)
      cmd_r == 8'h8F && cnt_r >= 7'd9 && cnt_r <= 7'd15 |-> dout == 1'b0;
  endproperty
  a_ctl_single: assert property (p_ctl_single) else $error("control low bits set");
  c_burst_rd: cover property (@(posedge sclk) cmd_r == `RTC_CMD_BURST_RD && cnt_r == 7'd71);
  c_burst_wr: cover property (@(posedge sclk) cmd_r == `RTC_CMD_BURST_WR && cnt_r == 7'd71);
  c_single_rd: cover property (@(posedge sclk) cmd_r == 8'h8F && cnt_r == 7'd15);
endmodule

bind rtc_core rtc_core_chk #(.XTAL_DIV(XTAL_DIV)) u_chk (
  .clk(clk),
  .rst_n(rst_n),
  .xtal_32k(xtal_32k),
  .sclk(sclk),
  .cs_n(cs_n),
  .din(din),
  .dout(dout),
  .dout_oe(dout_oe)
);

// ---- rtc_spi_master.sv ----
// Serial bus master model for the clock block's link
`timescale 1ns/10ps
module rtc_spi_master (
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout
);
  int hp = 15;
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b0;
  end
  // ========
  // One framed transfer, clock idles high
  task automatic frame(input logic [79:0] tx, input int nb, output logic [79:0] rx);
    rx = '0;
    cs_n = 1'b0;
    #40;
    // launch on fall, sample on rise, MSB first
    for (int i = 0; i < nb; i++) begin
      sclk = 1'b0;
      din = tx[79-i];
      #(hp);
      rx[79-i] = dout;
      sclk = 1'b1;
      #(hp);
    end
    #20;
    cs_n = 1'b1;
    din = ~din;
    #400;
  endtask
endmodule

// ---- rtc_core_test.sv ----
// Self-checking bench for the clock block
`timescale 1ns/10ps
`include "rtc_consts.svh"
module rtc_core_test;
  import rtc_pkg::*;
  localparam int DIV = 4;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic xtal_32k = 1'b0;
  logic sclk;
  logic cs_n;
  logic din;
  logic dout;
  logic dout_oe;
  logic [79:0] rx;
  int mismatches = 0;
  int total_checks = 0;
  always #10 clk = ~clk;
  rtc_spi_master m (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
  rtc_core #(.XTAL_DIV(DIV)) dut (
    .clk(clk),
    .rst_n(rst_n),
    .xtal_32k(xtal_32k),
    .sclk(sclk),
    .cs_n(cs_n),
    .din(din),
    .dout(dout),
    .dout_oe(dout_oe)
  );
  // ========
  // Shared tasks
  task automatic tally_and_finish();
    if (mismatches == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic cmp8(input string what, input rtc_byte_t exp, input rtc_byte_t got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic read_all(input logic [63:0] exp);
    m.frame({`RTC_CMD_BURST_RD, 72'h0}, 72, rx);
    for (int i = 0; i < 8; i++) begin
      cmp8("burst byte", exp[63-8*i -: 8], rx[71-8*i -: 8]);
    end
  endtask
  task automatic wr_all(input logic [63:0] v, input int nb);
    m.frame({`RTC_CMD_BURST_WR, v, 8'h00}, nb, rx);
  endtask
  task automatic wr1(input rtc_byte_t c, input rtc_byte_t v);
    m.frame({c, v, 64'h0}, 16, rx);
  endtask
  task automatic rd1(input rtc_byte_t c, input rtc_byte_t exp);
    m.frame({c, 72'h0}, 16, rx);
    cmp8("single read", exp, rx[71:64]);
  endtask
  // Whole crystal periods, n seconds
  task automatic tick(input int n);
    repeat (n * DIV) begin
      @(negedge clk);
      xtal_32k = 1'b1;
      repeat (5) @(negedge clk);
      xtal_32k = 1'b0;
      repeat (4) @(negedge clk);
    end
    repeat (10) @(negedge clk);
  endtask
  // ========
  // Scenarios
  task automatic t_reset_values();
    read_all(64'h00_00_00_01_01_01_70_00);
    // Output enable up once the read command is in
    fork
      rd1(8'h93, 8'h19);
      begin
        #410;
        cmp8("dout_oe in read", 8'h01, {7'h00, dout_oe});
      end
    join
    cmp8("dout_oe idle", 8'h00, {7'h00, dout_oe});
  endtask
  task automatic t_burst_12h();
    wr_all(64'h58_59_B1_04_07_05_02_00, 72);
    read_all(64'h58_59_B1_04_07_05_02_00);
    tick(2);
    read_all(64'h00_00_92_05_07_06_02_00);
  endtask
  task automatic t_burst_24h();
    wr_all(64'h59_59_19_31_12_07_99_00, 72);
    tick(1);
    read_all(64'h00_00_20_31_12_07_99_00);
  endtask
  task automatic t_snapshot();
    fork
      begin
        #500;
        tick(1);
      end
      read_all(64'h00_00_20_31_12_07_99_00);
    join
    read_all(64'h01_00_20_31_12_07_99_00);
  endtask
  task automatic t_abort();
    wr_all(64'h11_22_03_04_05_06_07_00, 68);
    wr_all(64'h11_22_03_04_05_06_07_00, 64);
    read_all(64'h01_00_20_31_12_07_99_00);
  endtask
  task automatic t_protect();
    m.hp = 40;
    wr1(8'h0F, 8'hFF);
    rd1(8'h8F, 8'h80);
    wr1(8'h01, 8'h33);
    rd1(8'h81, 8'h01);
    wr_all(64'h12_34_05_06_07_01_08_80, 72);
    read_all(64'h01_00_20_31_12_07_99_80);
    m.hp = 15;
    wr1(8'h0F, 8'h00);
    wr1(8'h01, 8'h33);
    rd1(8'h81, 8'h33);
    wr1(8'h00, 8'h44);
    rd1(8'h81, 8'h33);
    wr1(8'h13, 8'h20);
    rd1(8'h93, 8'h20);
  endtask
  task automatic t_single_time();
    wr1(8'h01, 8'h45);
    rd1(8'h81, 8'h45);
    wr1(8'h03, 8'h30);
    wr1(8'h05, 8'h07);
    rd1(8'h81, 8'h45);
    // Select rises four bits into the data byte
    m.frame({8'h03, 8'h55, 64'h0}, 12, rx);
    rd1(8'h81, 8'h45);
    rd1(8'h83, 8'h30);
    rd1(8'h85, 8'h07);
    rd1(8'h81, 8'h45);
  endtask
  // ========
  // Main sequence and watchdog
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (20) @(negedge clk);
    t_reset_values();
    t_burst_12h();
    t_burst_24h();
    t_snapshot();
    t_abort();
    t_protect();
    t_single_time();
    tally_and_finish();
  end
  initial begin
    #1500000;
    mismatches++;
    tally_and_finish();
  end
endmodule
